//--- core/imu_pkg.sv
// Constants and encodings shared by the integer multiply unit
// Summary of operation
// - A multiply runs only when its condition passed, otherwise no register or flag is written.
// - The short multiply writes first source times second source and ignores the accumulate operand.
// - The short multiply-accumulate adds the accumulate operand to the product and writes the sum.
// - The short forms return the low 32 bits of the product, the same for signed and unsigned.
// - Flags are written only when the flag-update bit of the instruction is set.
// - A flag-updating short form sets N from bit 31 and Z on a zero result, leaving V unchanged.
// - A short form takes 6 cycles less an early-termination saving of 0 to 3, so 3 to 6 cycles.
// - A long multiply forms a 64-bit product, low half to the low and high half to the high destination.
// - A long multiply-accumulate adds the 64-bit pair read from the destinations to the product.
// - Unsigned long forms treat every operand as unsigned, signed long forms as two's complement.
// - A flag-updating long form sets N from bit 63 and Z when all 64 result bits are zero.
// - A long form takes 7 cycles less an early-termination saving of 0 to 3, so 4 to 7 cycles.
package imu_pkg;

	////////////////////////////////////////////////////////////////////////////////////////
	// Operation codes: bit 2 long, bit 1 signed, bit 0 accumulate
	localparam logic [2:0] OP_SHORT_MULTIPLY                      = 3'h0;
	localparam logic [2:0] OP_SHORT_MULTIPLY_ACCUMULATE           = 3'h1;
	localparam logic [2:0] OP_UNSIGNED_LONG_MULTIPLY              = 3'h4;
	localparam logic [2:0] OP_UNSIGNED_LONG_MULTIPLY_ACCUMULATE   = 3'h5;
	localparam logic [2:0] OP_SIGNED_LONG_MULTIPLY                = 3'h6;
	localparam logic [2:0] OP_SIGNED_LONG_MULTIPLY_ACCUMULATE     = 3'h7;
	localparam int         OP_BIT_ACC                             = 0;
	localparam int         OP_BIT_SIGNED                          = 1;
	localparam int         OP_BIT_LONG                            = 2;

	////////////////////////////////////////////////////////////////////////////////////////
	// Flag nibble layout of the current program status
	localparam int         FLAG_N                                 = 3;
	localparam int         FLAG_Z                                 = 2;
	localparam int         FLAG_C                                 = 1;
	localparam int         FLAG_V                                 = 0;

	////////////////////////////////////////////////////////////////////////////////////////
	// Timing in core cycles
	localparam logic [2:0] SHORT_BASE_CYC                         = 3'h6;
	localparam logic [2:0] LONG_BASE_CYC                          = 3'h7;
	localparam logic [2:0] SHORT_MIN_CYC                          = 3'h3;
	localparam logic [2:0] LONG_MIN_CYC                           = 3'h4;
	localparam logic [2:0] SKIP_CYC                               = 3'h1;
	localparam logic [2:0] CNT_ONE                                = 3'h1;
	localparam logic [2:0] CNT_ZERO                               = 3'h0;

	////////////////////////////////////////////////////////////////////////////////////////
	// Control states, one-hot
	typedef enum logic [1:0] {
		ST_IDLE = 2'h1,
		ST_RUN  = 2'h2
	} imu_state_e;

endpackage

//--- core/imu_multiply_unit.sv
// Integer multiply and multiply-accumulate execution unit
`timescale 1ns/1ps

module imu_multiply_unit #(
	parameter int DATA_W = 32
) (
	// Clock and reset
	input  wire logic                core_clk,
	input  wire logic                rst_b,
	// Issue from the decoder
	input  wire logic                issue,
	input  wire logic [2:0]          op,
	input  wire logic                cond_pass,
	input  wire logic                set_flags,
	input  wire logic [1:0]          early_term,
	// Operands from the register file
	input  wire logic [DATA_W-1:0]   first_source_operand,
	input  wire logic [DATA_W-1:0]   second_source_operand,
	input  wire logic [DATA_W-1:0]   accumulate_operand,
	input  wire logic [DATA_W-1:0]   high_destination_register,
	input  wire logic [3:0]          flags_in,
	// Status toward the pipeline
	output logic                     busy,
	output logic                     done,
	// Write-back to the register file and status
	output logic                     wr_lo,
	output logic                     wr_hi,
	output logic [DATA_W-1:0]        result_lo,
	output logic [DATA_W-1:0]        result_hi,
	output logic                     flags_wr,
	output logic [3:0]               flags_out
);

	////////////////////////////////////////////////////////////////////////////////////////
	// State record
	typedef struct packed {
		imu_pkg::imu_state_e st;
		logic [2:0]          cnt;
		logic                is_long;
		logic                exec;
		logic                sflag;
		logic                busy;
		logic                done;
		logic                wr_lo;
		logic                wr_hi;
		logic                flags_wr;
		logic [DATA_W-1:0]   res_lo;
		logic [DATA_W-1:0]   res_hi;
		logic [3:0]          flags;
	} imu_state_s;

	imu_state_s            r;
	imu_state_s            next_r;
	logic [2*DATA_W-1:0]   op_a;
	logic [2*DATA_W-1:0]   op_b;
	logic [2*DATA_W-1:0]   addend;
	logic [2*DATA_W-1:0]   product;
	logic [2*DATA_W-1:0]   sum;
	logic                  take;
	logic                  is_long_in;
	logic [2:0]            len;

	////////////////////////////////////////////////////////////////////////////////////////
	// Datapath: widen to 64 bits, then multiply and add modulo 2^64
	always_comb begin
		is_long_in = op[imu_pkg::OP_BIT_LONG];
		// Sign-extension gives the right low 64 bits of a two's-complement product
		if (is_long_in && op[imu_pkg::OP_BIT_SIGNED]) begin
			op_a = {{DATA_W{first_source_operand[DATA_W-1]}}, first_source_operand};
			op_b = {{DATA_W{second_source_operand[DATA_W-1]}}, second_source_operand};
		end else begin
			op_a = {{DATA_W{1'b0}}, first_source_operand};
			op_b = {{DATA_W{1'b0}}, second_source_operand};
		end
		// Short forms use one datapath since only low bits are kept
		if (!op[imu_pkg::OP_BIT_ACC]) begin
			addend = '0;
		end else if (is_long_in) begin
			addend = {high_destination_register, accumulate_operand};
		end else begin
			addend = {{DATA_W{1'b0}}, accumulate_operand};
		end
		product = 64'(op_a * op_b);
		sum     = 64'(product + addend);
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// Issue acceptance and latency from the early-termination saving
	assign take = issue && !r.busy;
	assign len  = 3'((is_long_in ? imu_pkg::LONG_BASE_CYC : imu_pkg::SHORT_BASE_CYC)
		- {1'b0, early_term});

	////////////////////////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb begin
		next_r          = r;
		next_r.done     = 1'b0;
		next_r.wr_lo    = 1'b0;
		next_r.wr_hi    = 1'b0;
		next_r.flags_wr = 1'b0;
		case (r.st)
			imu_pkg::ST_IDLE: begin
				if (take) begin
					next_r.st      = imu_pkg::ST_RUN;
					next_r.busy    = 1'b1;
					next_r.is_long = is_long_in;
					next_r.exec    = cond_pass;
					next_r.sflag   = cond_pass && set_flags;
					next_r.flags   = flags_in;
					if (!cond_pass) begin
						// Skipped: one cycle, nothing written
						next_r.cnt  = imu_pkg::SKIP_CYC - imu_pkg::CNT_ONE;
						next_r.done = 1'b1;
					end else begin
						next_r.cnt = len - imu_pkg::CNT_ONE;
						if (is_long_in) begin
							next_r.res_lo = sum[DATA_W-1:0];
							next_r.res_hi = sum[2*DATA_W-1:DATA_W];
						end else begin
							next_r.res_lo = sum[DATA_W-1:0];
						end
						if (set_flags) begin
							// C is left as it was, which is one of the allowed values
							if (is_long_in) begin
								next_r.flags[imu_pkg::FLAG_N] = sum[2*DATA_W-1];
								next_r.flags[imu_pkg::FLAG_Z] = (sum == '0);
							end else begin
								next_r.flags[imu_pkg::FLAG_N] = sum[DATA_W-1];
								next_r.flags[imu_pkg::FLAG_Z] = (sum[DATA_W-1:0] == '0);
							end
						end
					end
				end
			end
			imu_pkg::ST_RUN: begin
				if (r.cnt == imu_pkg::CNT_ZERO) begin
					// Final busy cycle just ended
					next_r.st   = imu_pkg::ST_IDLE;
					next_r.busy = 1'b0;
				end else begin
					next_r.cnt = 3'(r.cnt - imu_pkg::CNT_ONE);
					if (r.cnt == imu_pkg::CNT_ONE) begin
						next_r.done     = 1'b1;
						next_r.wr_lo    = r.exec;
						next_r.wr_hi    = r.exec && r.is_long;
						next_r.flags_wr = r.sflag;
					end
				end
			end
			default: begin
				next_r.st   = imu_pkg::ST_IDLE;
				next_r.busy = 1'b0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			r       <= '0;
			r.st    <= imu_pkg::ST_IDLE;
			r.flags <= 4'h0;
		end else begin
			r <= next_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// Outputs straight from the state register
	assign busy      = r.busy;
	assign done      = r.done;
	assign wr_lo     = r.wr_lo;
	assign wr_hi     = r.wr_hi;
	assign result_lo = r.res_lo;
	assign result_hi = r.res_hi;
	assign flags_wr  = r.flags_wr;
	assign flags_out = r.flags;

	////////////////////////////////////////////////////////////////////////////////////////
	// Checking helpers: cycles since issue, and the reference sum and incoming flags kept for result checks
	logic [3:0]          hlp_cyc;
	logic [2*DATA_W-1:0] hlp_sum;
	logic [3:0]          hlp_flags;
	logic [2*DATA_W-1:0] hlp_prod;
	logic [2*DATA_W-1:0] hlp_add;

	// Reference built with casts, not the datapath's replication, so a slip there still shows
	always_comb begin
		if (op[imu_pkg::OP_BIT_LONG] && op[imu_pkg::OP_BIT_SIGNED]) begin
			hlp_prod = 64'($signed(first_source_operand)) * 64'($signed(second_source_operand));
		end else begin
			hlp_prod = 64'(first_source_operand) * 64'(second_source_operand);
		end
		if (!op[imu_pkg::OP_BIT_ACC]) begin
			hlp_add = 64'h0;
		end else if (op[imu_pkg::OP_BIT_LONG]) begin
			hlp_add = {high_destination_register, accumulate_operand};
		end else begin
			hlp_add = 64'(accumulate_operand);
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			hlp_cyc   <= 4'h0;
			hlp_sum   <= '0;
			hlp_flags <= 4'h0;
		end else if (take) begin
			hlp_cyc   <= 4'h1;
			hlp_sum   <= 64'(hlp_prod + hlp_add);
			hlp_flags <= flags_in;
		end else if (r.busy) begin
			hlp_cyc   <= 4'(hlp_cyc + 4'h1);
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// Assertions
	sequence seq_issue_ok;
		take && cond_pass;
	endsequence

	sequence seq_running;
		busy && !done;
	endsequence

	sequence seq_finishing;
		busy && done;
	endsequence

	AST_SKIP_NO_WRITE: assert property (@(posedge core_clk) disable iff (!rst_b)
		take && !cond_pass |=> done && !wr_lo && !wr_hi && !flags_wr)
		else $error("skipped multiply wrote a result");

	AST_BUSY_HELD: assert property (@(posedge core_clk) disable iff (!rst_b)
		seq_issue_ok |=> seq_running ##[2:6] seq_finishing)
		else $error("executed multiply did not finish in time");

	// Busy may only fall after the done cycle, so the pipeline never races the write
	AST_BUSY_STAYS: assert property (@(posedge core_clk) disable iff (!rst_b)
		busy && !done |=> busy)
		else $error("busy dropped before done");

	AST_SHORT_LATENCY: assert property (@(posedge core_clk) disable iff (!rst_b)
		done && wr_lo && !wr_hi |-> hlp_cyc >= 4'h3 && hlp_cyc <= 4'h6)
		else $error("short multiply latency outside 3 to 6");

	AST_LONG_LATENCY: assert property (@(posedge core_clk) disable iff (!rst_b)
		done && wr_hi |-> hlp_cyc >= 4'h4 && hlp_cyc <= 4'h7)
		else $error("long multiply latency outside 4 to 7");

	AST_SHORT_RESULT: assert property (@(posedge core_clk) disable iff (!rst_b)
		done && wr_lo && !wr_hi |-> result_lo == hlp_sum[DATA_W-1:0])
		else $error("short result wrong");

	AST_LONG_RESULT: assert property (@(posedge core_clk) disable iff (!rst_b)
		done && wr_hi |-> wr_lo && {result_hi, result_lo} == hlp_sum)
		else $error("long result wrong");

	AST_FLAGS_GATED: assert property (@(posedge core_clk) disable iff (!rst_b)
		seq_issue_ok ##0 !set_flags |-> ##[1:7] (done && !flags_wr))
		else $error("flags written without update bit");

	AST_SHORT_FLAGS: assert property (@(posedge core_clk) disable iff (!rst_b)
		flags_wr && !wr_hi |-> flags_out[imu_pkg::FLAG_N] == result_lo[DATA_W-1]
		&& flags_out[imu_pkg::FLAG_Z] == (result_lo == '0)
		&& flags_out[imu_pkg::FLAG_V] == hlp_flags[imu_pkg::FLAG_V])
		else $error("short flags wrong");

	AST_LONG_FLAGS: assert property (@(posedge core_clk) disable iff (!rst_b)
		flags_wr && wr_hi |-> flags_out[imu_pkg::FLAG_N] == result_hi[DATA_W-1]
		&& flags_out[imu_pkg::FLAG_Z] == ({result_hi, result_lo} == '0))
		else $error("long flags wrong");

endmodule

//--- testbench/imu_decoder_model.sv
// Decoder and register-file model issuing multiply requests
`timescale 1ns/1ps

module imu_decoder_model (
	// Clock and status
	input  wire logic        core_clk,
	input  wire logic        busy,
	// Request toward the unit
	output logic             issue,
	output logic [2:0]       op,
	output logic             cond_pass,
	output logic             set_flags,
	output logic [1:0]       early_term,
	output logic [31:0]      first_source_operand,
	output logic [31:0]      second_source_operand,
	output logic [31:0]      accumulate_operand,
	output logic [31:0]      high_destination_register,
	output logic [3:0]       flags_in,
	output logic             timed_out
);
	////////////////////////////////////////////////////////////////////////////////
	// Idle values at time zero
	initial begin
		{issue, op, cond_pass, set_flags, early_term, timed_out} = '0;
		{first_source_operand, second_source_operand, accumulate_operand} = '0;
		{high_destination_register, flags_in} = '0;
	end

	// Hold the request until an edge with busy low takes it; busy moves only on edges
	task automatic send(input logic [2:0] o, input logic [3:0] c, input logic [131:0] d);
		int n;
		op = o;
		{cond_pass, set_flags, early_term} = c;
		{first_source_operand, second_source_operand, accumulate_operand,
			high_destination_register, flags_in} = d;
		issue = 1'b1;
		for (n = 0; n < 20 && busy !== 1'b0; n++) begin
			@(posedge core_clk);
			#1;
		end
		timed_out = (n == 20);
		@(posedge core_clk);
		#1;
		issue = 1'b0;
		// Stale operands inverted so a late sample cannot match by luck
		{first_source_operand, second_source_operand, accumulate_operand,
			high_destination_register, flags_in} = ~d;
	endtask
endmodule

//--- testbench/integer_multiply_unit_test.sv
// Self-checking testbench of the integer multiply unit
`timescale 1ns/1ps

module integer_multiply_unit_test;
	logic core_clk, rst_b, issue, cond_pass, set_flags, timed_out;
	logic busy, done, wr_lo, wr_hi, flags_wr;
	logic [2:0] op;
	logic [1:0] early_term;
	logic [31:0] src_a, src_b, acc_lo, acc_hi, result_lo, result_hi;
	logic [3:0] flags_in, flags_out;
	int seed, i, n_mismatch, checks;
	logic [2:0] ops [6] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6, 3'h7};

	imu_multiply_unit uut (.core_clk(core_clk), .rst_b(rst_b), .issue(issue), .op(op),
		.cond_pass(cond_pass), .set_flags(set_flags), .early_term(early_term),
		.first_source_operand(src_a), .second_source_operand(src_b),
		.accumulate_operand(acc_lo), .high_destination_register(acc_hi),
		.flags_in(flags_in), .busy(busy), .done(done), .wr_lo(wr_lo), .wr_hi(wr_hi),
		.result_lo(result_lo), .result_hi(result_hi), .flags_wr(flags_wr),
		.flags_out(flags_out));

	imu_decoder_model dec (.core_clk(core_clk), .busy(busy), .issue(issue), .op(op),
		.cond_pass(cond_pass), .set_flags(set_flags), .early_term(early_term),
		.first_source_operand(src_a), .second_source_operand(src_b),
		.accumulate_operand(acc_lo), .high_destination_register(acc_hi),
		.flags_in(flags_in), .timed_out(timed_out));

	////////////////////////////////////////////////////////////////////////////////
	// 25 MHz core clock
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	// Compare and count
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_sim;
		$display("checks %0d n_mismatch %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	function automatic logic [31:0] rnd();
		return $random(seed);
	endfunction

	// Reference product; short forms keep only the low word
	function automatic logic [63:0] ref_res(logic [2:0] o, logic [127:0] d);
		logic [31:0] a, b, c, h;
		logic [63:0] p;
		{a, b, c, h} = d;
		if (o[2] && o[1]) begin
			p = $signed({{32{a[31]}}, a}) * $signed({{32{b[31]}}, b});
		end else begin
			p = {32'h0, a} * {32'h0, b};
		end
		if (o[0]) begin
			p = p + (o[2] ? {h, c} : {32'h0, c});
		end
		return o[2] ? p : {32'h0, p[31:0]};
	endfunction

	// One request: c is {cond_pass, set_flags, early_term}
	task automatic run(input logic [2:0] o, input logic [3:0] c, input logic [131:0] d);
		int k;
		int len;
		logic [63:0] r;
		r = ref_res(o, d[131:4]);
		len = c[3] ? (o[2] ? 7 : 6) - int'(c[1:0]) : 1;
		dec.send(o, c, d);
		chk(64'(timed_out), 64'h0);
		if (timed_out === 1'b1) end_sim();
		for (k = 1; k < 9; k++) begin
			if (k > 1) begin
				@(posedge core_clk);
				#1;
			end
			chk(64'(busy), 64'h1);
			if (done === 1'b1) break;
		end
		chk(64'(k), 64'(len));
		// A lost done pulse leaves the unit in an unknown state, so stop here
		if (k > 8) end_sim();
		chk(64'({wr_lo, wr_hi, flags_wr}), 64'({c[3], c[3] & o[2], c[3] & c[2]}));
		if (c[3]) begin
			chk(o[2] ? {result_hi, result_lo} : 64'(result_lo), r);
		end
		if (c[3] & c[2] & o[2]) begin
			chk(64'(flags_out[3:2]), 64'({r[63], r == 64'h0}));
		end
		if (c[3] & c[2] & ~o[2]) begin
			chk(64'({flags_out[3:2], flags_out[0]}), 64'({r[31], r[31:0] == 32'h0, d[0]}));
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Corner cases first, then random traffic issued back to back
	initial begin
		seed = 32'hea78;
		n_mismatch = 0;
		checks = 0;
		rst_b = 1'b0;
		repeat (6) @(posedge core_clk);
		#1;
		rst_b = 1'b1;
		for (i = 0; i < 6; i++) begin
			run(ops[i], {2'b11, 2'(i)}, {32'hfffffff6, 32'h14, rnd(), rnd(), 4'h5});
		end
		// Zero product with a stray addend on the plain short form
		for (i = 0; i < 6; i++) begin
			run(ops[i], {2'b11, 2'(3 - i % 4)}, {32'h0, rnd(), i == 0 ? rnd() : 32'h0, 36'ha});
		end
		for (i = 0; i < 60; i++) begin
			run(ops[$unsigned($random(seed)) % 6], 4'(rnd()), {rnd(), rnd(), rnd(), rnd(), 4'(rnd())});
		end
		end_sim();
	end
endmodule
